//--- port_io_clock_blocks.sv
// clocked i/o ports, their clock blocks and pin arbitration behind apb
// assumes pins are resolved outside from pin_out/pin_oe; pins arrive async
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module port_io_clock_blocks
    import pio_pkg::*;
(
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic [31:0]               prdata,
    // pins
    input  wire logic [PIN_COUNT-1:0] pin_in,
    output logic [PIN_COUNT-1:0]      pin_out,
    output logic [PIN_COUNT-1:0]      pin_oe,
    output logic                      pin_pull_down,
    // strobes
    input  wire logic [NUM_PORTS-1:0] ready_in_strobe,
    output logic [NUM_PORTS-1:0]      output_valid_strobe,
    // scheduler events
    output logic [NUM_PORTS-1:0]      port_event
);

    state_s s;
    state_s next_s;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic        acc;
    logic        setup;
    logic        in_ports;
    logic [2:0]  pidx;
    logic [5:0]  roff;
    logic [2:0]  cidx;
    logic        is_cb;
    logic        mapped;

    always_comb
    begin
        acc      = psel & penable;
        setup    = psel & ~penable;
        in_ports = paddr < PORT_SPAN;
        pidx     = paddr[8:6];
        roff     = paddr[5:0];
        cidx     = paddr[4:2];
        is_cb    = (paddr[11:5] == REG_CLKBLK_BASE[11:5]) && (cidx < 3'(NUM_CLKBLK));
        mapped   = (in_ports && roff <= REG_STATUS && roff[1:0] == 2'b00)
                 || (is_cb && paddr[1:0] == 2'b00) || paddr == REG_LINK;
    end

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = s.prdata;
    assign pin_pull_down = s.pull_down;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [NUM_CLKBLK-1:0]           cb_tick;
    logic [NUM_PORTS-1:0][31:0]      own;
    logic [NUM_PORTS-1:0]            claimed;
    logic [31:0]                     mask;
    logic [31:0]                     sample;
    logic [5:0]                      nchunk;
    logic [5:0]                      wsh;
    logic                            go;
    logic                            met;
    logic [31:0]                     rd;
    logic [31:0]                     po;
    logic [31:0]                     poe;
    logic [NUM_PORTS-1:0]            ev;
    logic [NUM_PORTS-1:0]            ovs;

    always_comb
    begin
        next_s  = s;
        cb_tick = '0;
        own     = '0;
        claimed = '0;
        mask    = '0;
        sample  = '0;
        nchunk  = '0;
        wsh     = '0;
        go      = 1'b0;
        met     = 1'b0;
        rd      = '0;
        po      = '0;
        poe     = '0;
        ev      = '0;
        ovs     = '0;

        // pins pass three flops; a level counts once stages two and three agree
        next_s.sync1  = {ready_in_strobe, pin_in};
        next_s.sync2  = s.sync1;
        next_s.sync3  = s.sync2;
        next_s.stable = (s.sync2 & s.sync3) | (s.stable & (s.sync2 ^ s.sync3));
        next_s.pin0_prev = s.stable[0];
        next_s.pull_down = 1'b0;

        // block 0 ticks every pclk: it stands in for the tile reference clock
        cb_tick[0] = 1'b1;
        for (int c = 1; c < NUM_CLKBLK; c++)
        begin
            if (!s.cb[c].cfg.from_pin || (s.stable[0] & ~s.pin0_prev))
            begin
                if (s.cb[c].divcnt >= s.cb[c].cfg.div)
                begin
                    cb_tick[c] = 1'b1;
                    next_s.cb[c].divcnt = '0;
                end
                else
                begin
                    next_s.cb[c].divcnt = s.cb[c].divcnt + 8'h01;
                end
            end
        end

        // narrowest enabled port owns a pin; link pins belong to no port
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                if (s.port[p].cfg.enable && i < PORT_WIDTH[p] && !s.link_pins[i]
                    && !claimed[0])
                begin
                    own[p][i]  = 1'b1;
                    claimed[0] = 1'b1;
                end
            end
            claimed[0] = 1'b0;
        end

        for (int p = 0; p < NUM_PORTS; p++)
        begin
            wsh    = 6'(PORT_WIDTH[p]);
            mask   = (PORT_WIDTH[p] == 32) ? 32'hFFFFFFFF : ((32'h1 << wsh) - 32'h1);
            nchunk = 6'(32 / PORT_WIDTH[p]);
            sample = s.stable[31:0] & own[p];
            met    = (s.port[p].cfg.cond == COND_EQ) ? (sample == (s.port[p].cond_val & mask))
                   : (sample != (s.port[p].cond_val & mask));
            if (s.port[p].cfg.clk_block < 3'(NUM_CLKBLK) && cb_tick[s.port[p].cfg.clk_block])
            begin
                next_s.port[p].ctr = s.port[p].ctr + 16'h0001;
                go = s.port[p].cfg.enable
                   && (!s.port[p].cfg.timed || s.port[p].ctr == s.port[p].time_val);
            end
            else
            begin
                go = 1'b0;
            end

            if (go && s.port[p].cfg.timed)
            begin
                next_s.port[p].cfg.timed = 1'b0;
            end

            if (s.port[p].cfg.drive)
            begin
                // whole port drives together; pins it does not own stay off
                for (int i = 0; i < PIN_COUNT; i++)
                begin
                    if (own[p][i])
                    begin
                        po[i]  = s.port[p].cfg.open_drain ? 1'b0 : s.port[p].shreg[i];
                        poe[i] = s.port[p].cfg.open_drain ? ~s.port[p].shreg[i] : 1'b1;
                    end
                end
                ovs[p] = s.port[p].cfg.enable && s.port[p].cfg.strobe_en
                       && s.port[p].chunks != 6'h00;
                if (go)
                begin
                    if (s.port[p].chunks > 6'h01)
                    begin
                        next_s.port[p].shreg  = s.port[p].shreg >> wsh;
                        next_s.port[p].chunks = s.port[p].chunks - 6'h01;
                    end
                    else if (s.port[p].xfer_full)
                    begin
                        next_s.port[p].shreg     = s.port[p].xfer;
                        next_s.port[p].chunks    = nchunk;
                        next_s.port[p].xfer_full = 1'b0;
                        next_s.port[p].stamp     = s.port[p].ctr;
                    end
                    else
                    begin
                        next_s.port[p].chunks = '0;
                    end
                end
            end
            else if (go && (!s.port[p].cfg.strobe_en || s.stable[PIN_COUNT+p]))
            begin
                if (s.port[p].cfg.cond != COND_NONE)
                begin
                    if (met)
                    begin
                        ev[p] = 1'b1;
                        next_s.port[p].cfg.cond = COND_NONE;
                    end
                end
                else
                begin
                    next_s.port[p].shreg = (s.port[p].shreg >> wsh) | (sample << (6'd32 - wsh));
                    if (s.port[p].chunks + 6'h01 >= nchunk)
                    begin
                        next_s.port[p].xfer      = next_s.port[p].shreg;
                        next_s.port[p].xfer_full = 1'b1;
                        next_s.port[p].chunks    = '0;
                        next_s.port[p].stamp     = s.port[p].ctr;
                        ev[p] = 1'b1;
                        if (pidx == 3'(p))
                        begin
                            next_s.rd_hold = 1'b0;
                        end
                    end
                    else
                    begin
                        next_s.port[p].chunks = s.port[p].chunks + 6'h01;
                    end
                end
            end
        end

        // read data is latched in the setup cycle so prdata is a flop
        if (setup)
        begin
            next_s.rd_hold = 1'b1;
            if (in_ports && pidx < 3'(NUM_PORTS))
            begin
                case (roff)
                    REG_CFG:    rd = 32'(s.port[pidx].cfg);
                    REG_DATA:   rd = s.port[pidx].xfer;
                    REG_COND:   rd = s.port[pidx].cond_val;
                    REG_TIME:   rd = {16'h0000, s.port[pidx].time_val};
                    REG_COUNT:  rd = {16'h0000, s.port[pidx].ctr};
                    REG_STAMP:  rd = {16'h0000, s.port[pidx].stamp};
                    REG_STATUS: rd = {22'h000000, s.port[pidx].chunks, s.port[pidx].cfg.timed,
                                      s.port[pidx].cfg.cond, s.port[pidx].xfer_full};
                    default:    rd = '0;
                endcase
            end
            else if (is_cb)
            begin
                rd = 32'(s.cb[cidx].cfg);
            end
            else if (paddr == REG_LINK)
            begin
                rd = s.link_pins;
            end
            next_s.prdata = rd;
        end

        // software writes come last so they win over hardware updates
        if (acc && in_ports && pidx < 3'(NUM_PORTS))
        begin
            if (pwrite)
            begin
                case (roff)
                    REG_CFG:  next_s.port[pidx].cfg      = port_cfg_s'(pwdata[9:0]);
                    REG_DATA:
                    begin
                        next_s.port[pidx].xfer      = pwdata;
                        next_s.port[pidx].xfer_full = 1'b1;
                    end
                    REG_COND: next_s.port[pidx].cond_val = pwdata;
                    REG_TIME: next_s.port[pidx].time_val = pwdata[15:0];
                    default:  next_s.port[pidx].cond_val = s.port[pidx].cond_val;
                endcase
            end
            else if (roff == REG_DATA && !s.port[pidx].cfg.drive && next_s.rd_hold)
            begin
                // a word landing in the access cycle keeps the flag set
                next_s.port[pidx].xfer_full = 1'b0;
            end
        end
        else if (acc && pwrite && is_cb && cidx != 3'h0)
        begin
            next_s.cb[cidx].cfg = clkblk_cfg_s'(pwdata[8:0]);
        end
        else if (acc && pwrite && paddr == REG_LINK)
        begin
            next_s.link_pins = pwdata;
        end
    end

    assign pin_out             = po;
    assign pin_oe              = poe;
    assign port_event          = ev;
    assign output_valid_strobe = ovs;

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s           <= '0;
            s.pull_down <= 1'b1;
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                s.port[p].cfg <= PORT_CFG_RESET;
            end
            for (int c = 0; c < NUM_CLKBLK; c++)
            begin
                s.cb[c].cfg <= CLKBLK_CFG_RESET;
            end
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule : port_io_clock_blocks

`default_nettype wire

//--- pio_pkg.sv
// constants and types for the clocked i/o port block
// assumes a single pclk domain and an apb master in front of it
package pio_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_PORTS   = 5;
    localparam int NUM_CLKBLK  = 6;
    localparam int PIN_COUNT   = 32;
    localparam int SYNC_W      = PIN_COUNT + NUM_PORTS;
    localparam int PORT_WIDTH [NUM_PORTS] = '{1, 4, 8, 16, 32};

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] PORT_SPAN       = 12'h140;
    localparam logic [5:0]  REG_CFG         = 6'h00;
    localparam logic [5:0]  REG_DATA        = 6'h04;
    localparam logic [5:0]  REG_COND        = 6'h08;
    localparam logic [5:0]  REG_TIME        = 6'h0C;
    localparam logic [5:0]  REG_COUNT       = 6'h10;
    localparam logic [5:0]  REG_STAMP       = 6'h14;
    localparam logic [5:0]  REG_STATUS      = 6'h18;
    localparam logic [11:0] REG_CLKBLK_BASE = 12'h200;
    localparam logic [11:0] REG_LINK        = 12'h220;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NE} cond_e;

    typedef struct packed {
        logic       timed;
        cond_e      cond;
        logic [2:0] clk_block;
        logic       strobe_en;
        logic       open_drain;
        logic       drive;
        logic       enable;
    } port_cfg_s;

    typedef struct packed {
        logic [7:0] div;
        logic       from_pin;
    } clkblk_cfg_s;

    typedef struct packed {
        port_cfg_s   cfg;
        logic [31:0] xfer;
        logic        xfer_full;
        logic [31:0] shreg;
        logic [5:0]  chunks;
        logic [15:0] ctr;
        logic [15:0] time_val;
        logic [15:0] stamp;
        logic [31:0] cond_val;
    } port_state_s;

    typedef struct packed {
        clkblk_cfg_s cfg;
        logic [7:0]  divcnt;
    } clkblk_state_s;

    typedef struct packed {
        port_state_s   [NUM_PORTS-1:0]  port;
        clkblk_state_s [NUM_CLKBLK-1:0] cb;
        logic [PIN_COUNT-1:0]           link_pins;
        logic [SYNC_W-1:0]              sync1;
        logic [SYNC_W-1:0]              sync2;
        logic [SYNC_W-1:0]              sync3;
        logic [SYNC_W-1:0]              stable;
        logic                           pin0_prev;
        logic                           pull_down;
        logic                           rd_hold;
        logic [31:0]                    prdata;
    } state_s;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam port_cfg_s   PORT_CFG_RESET   = '0;
    localparam clkblk_cfg_s CLKBLK_CFG_RESET = '0;

endpackage : pio_pkg

//--- pio_monitor.sv
// concurrent checks on the port block's apb, pin and event outputs
// assumes it is bound onto port_io_clock_blocks and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module pio_monitor
    import pio_pkg::*;
(
    // clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // apb
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [31:0]          prdata,
    // pins, strobes, events
    input wire logic [PIN_COUNT-1:0] pin_in,
    input wire logic [PIN_COUNT-1:0] pin_out,
    input wire logic [PIN_COUNT-1:0] pin_oe,
    input wire logic                 pin_pull_down,
    input wire logic [NUM_PORTS-1:0] ready_in_strobe,
    input wire logic [NUM_PORTS-1:0] output_valid_strobe,
    input wire logic [NUM_PORTS-1:0] port_event
);
    default clocking mon_clk @(posedge pclk);
    endclocking

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    pready_high_a: assert property (disable iff (!presetn) pready)
        else $error("pready low in a cycle");
    slverr_access_a: assert property (disable iff (!presetn)
        pslverr |-> psel && penable) else $error("pslverr outside access");
    unmapped_err_a: assert property (disable iff (!presetn)
        psel && penable && paddr >= 12'h224 |-> pslverr) else $error("no error on hole");
    mapped_ok_a: assert property (disable iff (!presetn)
        psel && penable && paddr <= 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped register");
    unmapped_zero_a: assert property (disable iff (!presetn)
        psel && !penable && !pwrite && paddr >= 12'h224 |=> prdata == 32'h0)
        else $error("hole read not zero");
    prdata_hold_a: assert property (disable iff (!presetn)
        !(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
    pull_release_a: assert property (presetn && $past(presetn) |-> !pin_pull_down)
        else $error("pull-down left on");
    reset_quiet_a: assert property (!presetn |-> pin_pull_down
        && pin_oe == '0 && port_event == '0) else $error("pins active in reset");
    event_single_a: assert property (disable iff (!presetn)
        port_event[2] |=> !port_event[2]) else $error("event held too long");

    // the main scenarios must really be reached
    cover property (port_event[2]);
    cover property (output_valid_strobe[1]);
    cover property (pslverr);
endmodule : pio_monitor
`default_nettype wire

//--- pin_partner.sv
// external hardware on the pads: resolves each pad and drives levels and strobes
// assumes the bench changes ext_en, ext_val and stb just after rising edges
`timescale 1ns/10ps
`default_nettype none
module pin_partner
    import pio_pkg::*;
(
    // clock
    input  wire logic                 pclk,
    // device side of the pads
    input  wire logic [PIN_COUNT-1:0] pin_out,
    input  wire logic [PIN_COUNT-1:0] pin_oe,
    input  wire logic                 pin_pull_down,
    output logic      [PIN_COUNT-1:0] pin_in,
    output logic      [NUM_PORTS-1:0] ready_in_strobe,
    // bench controls
    input  wire logic                 ext_en,
    input  wire logic [PIN_COUNT-1:0] ext_val,
    input  wire logic                 stb
);
    logic [PIN_COUNT-1:0] last;

    // a floating pad flips each cycle so stages two and three never agree and the last agreed level is held
    always_comb
    begin
        for (int i = 0; i < PIN_COUNT; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en ? ext_val[i]
                      : pin_pull_down ? 1'b0 : ~last[i];
    end

    always_ff @(posedge pclk) last <= pin_in;

    assign ready_in_strobe = {NUM_PORTS{stb}};
endmodule : pin_partner
`default_nettype wire

//--- tb_port_io_clock_blocks.sv
// self-checking bench: apb register calls and pin observation
// assumes pin_partner on the pads and pio_monitor bound at the foot
`timescale 1ns/10ps
`default_nettype none
module tb_port_io_clock_blocks
    import pio_pkg::*;
;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, q, q2;
    logic [PIN_COUNT-1:0] pin_in, pin_out, pin_oe, ext_val;
    logic [NUM_PORTS-1:0] ready_in_strobe, output_valid_strobe, port_event;
    logic                 pin_pull_down, ext_en, stb, e, hit;
    int                   fails, compares, cyc;

    port_io_clock_blocks u_port_io_clock_blocks (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_down(pin_pull_down), .ready_in_strobe(ready_in_strobe),
        .output_valid_strobe(output_valid_strobe), .port_event(port_event));
    pin_partner u_pin_partner (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_down(pin_pull_down), .pin_in(pin_in),
        .ready_in_strobe(ready_in_strobe), .ext_en(ext_en), .ext_val(ext_val), .stb(stb));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // k selects the event lines, otherwise the output strobes
    task automatic wait_bit(input int k, input int p);
        int n;
        n = 0;
        @(negedge pclk);
        while ((k ? port_event[p] : output_valid_strobe[p]) !== 1'b1 && n < 200)
        begin
            @(negedge pclk);
            n++;
        end
        chk("wait", 32'(n < 200), 32'h1);
    endtask : wait_bit

    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // a hang counts as a mismatch and still reaches the report
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            fails++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        {psel, penable, pwrite, ext_en, stb, hit} = '0;
        {paddr, pwdata, ext_val} = '0;
        {fails, compares, cyc} = '0;
        // a clean falling edge before the first clock so the reset is never missed
        presetn = 1'b1;
        #1 presetn = 1'b0;
        repeat (12) @(posedge pclk);
        chk("pull_rst", 32'(pin_pull_down), 32'h1);
        presetn <= 1'b1;
        @(negedge pclk);
        @(negedge pclk);
        chk("pull_run", 32'(pin_pull_down), 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk("cfg_rst", q, 32'h0);
        apb(1'b1, 12'h200, 32'h1FF);
        apb(1'b0, 12'h200, 32'h0);
        chk("cb0_ro", q, 32'h0);
        apb(1'b1, 12'h204, 32'h0B);
        apb(1'b0, 12'h204, 32'h0);
        chk("cb1_rw", q, 32'h0B);
        apb(1'b0, 12'h300, 32'h0);
        chk("hole_err", 32'(e), 32'h1);
        chk("hole_data", q, 32'h0);
        // 4-bit output port streams 8 nibbles, low nibble first, held until count+40
        apb(1'b0, 12'h050, 32'h0);
        q2 = (q + 32'd40) & 32'hFFFF;
        apb(1'b1, 12'h04C, q2);
        apb(1'b1, 12'h040, 32'h20B);
        apb(1'b1, 12'h044, 32'h8765_4321);
        wait_bit(0, 1);
        chk("p1_dir", 32'(pin_oe[3:0]), 32'hF);
        for (int i = 0; i < 8; i++)
        begin
            chk("p1_chunk", 32'(pin_out[3:0]), 32'(i + 1));
            @(negedge pclk);
        end
        chk("p1_idle", 32'(output_valid_strobe[1]), 32'h0);
        apb(1'b0, 12'h054, 32'h0);
        chk("p1_stamp", q, q2);
        apb(1'b0, 12'h050, 32'h0);
        q2 = q;
        apb(1'b0, 12'h050, 32'h0);
        chk("count", (q - q2) & 32'hFFFF, 32'h3);
        // open drain on the 1-bit port, overlapping the 4-bit port
        apb(1'b1, 12'h000, 32'h0F);
        apb(1'b1, 12'h004, 32'hFFFF_FFFE);
        wait_bit(0, 0);
        chk("od_low", 32'({pin_oe[0], pin_out[0]}), 32'h2);
        chk("wide_keep", 32'(pin_oe[3:1]), 32'h7);
        @(negedge pclk);
        chk("od_float", 32'({pin_oe[0], pin_out[0]}), 32'h0);
        apb(1'b1, 12'h220, 32'h2);
        @(negedge pclk);
        chk("link_take", 32'(pin_oe[3:1]), 32'h6);
        apb(1'b1, 12'h220, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h040, 32'h0);
        @(negedge pclk);
        chk("released", 32'(pin_oe), 32'h0);
        // 8-bit input held off by the qualifying strobe
        @(posedge pclk);
        ext_en  <= 1'b1;
        ext_val <= 32'h3C3C_3C3C;
        apb(1'b1, 12'h080, 32'h09);
        repeat (20)
        begin
            @(negedge pclk);
            if (port_event[2] === 1'b1)
                hit = 1'b1;
        end
        chk("stb_hold", 32'(hit), 32'h0);
        @(posedge pclk);
        stb <= 1'b1;
        wait_bit(1, 2);
        apb(1'b0, 12'h084, 32'h0);
        chk("p2_word", q, 32'h3C3C_3C3C);
        // 16-bit input waits for an equal pin pattern
        apb(1'b1, 12'h080, 32'h0);
        apb(1'b1, 12'h0C8, 32'h5A5A);
        apb(1'b1, 12'h0C0, 32'h81);
        @(posedge pclk);
        ext_val <= 32'h5A5A_5A5A;
        wait_bit(1, 3);
        wait_bit(1, 3);
        apb(1'b0, 12'h0C4, 32'h0);
        chk("p3_word", q, 32'h5A5A_5A5A);
        apb(1'b0, 12'h0D8, 32'h0);
        chk("p3_cond", (q >> 1) & 32'h3, 32'h0);
        // clock block 1 ticks once per six rising edges on pin 0
        apb(1'b1, 12'h100, 32'h10);
        apb(1'b0, 12'h110, 32'h0);
        q2 = q;
        // two-cycle levels so the synchroniser stages agree on each one
        repeat (24)
        begin
            repeat (2) @(posedge pclk);
            ext_val[0] <= ~ext_val[0];
        end
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h110, 32'h0);
        chk("cb1_pin_div", (q - q2) & 32'hFFFF, 32'h2);
        summarize();
    end
endmodule : tb_port_io_clock_blocks

bind port_io_clock_blocks pio_monitor u_pio_monitor (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_down(pin_pull_down), .ready_in_strobe(ready_in_strobe),
    .output_valid_strobe(output_valid_strobe), .port_event(port_event));
`default_nettype wire
